// file: shared/wavegen_pkg.sv
`default_nettype none
package wavegen_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned LEN_W  = 3;
  localparam int unsigned SYNC_N = 2;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the 8-bit host bus)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] HIGH_PHASE_LENGTH_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] LOW_PHASE_LENGTH_OFS  = 8'h01;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [LEN_W-1:0] LENGTH_RST  = 3'h0;
  localparam logic [LEN_W-1:0] COUNT_RST   = 3'h0;
  localparam logic             WAVE_RST    = 1'b0;
  localparam logic             PULSE_N_RST = 1'b1;
  localparam logic [SYNC_N-1:0] SYNC_HI_RST = 2'h3;
  localparam logic [SYNC_N-1:0] SYNC_LO_RST = 2'h0;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [LEN_W-1:0] TERM_VALUE = 3'h1;
  localparam logic [LEN_W-1:0] COUNT_STEP = 3'h1;
  localparam logic [LEN_W-1:0] LEN_MIN    = 3'h2;
  localparam logic [LEN_W-1:0] LEN_MAX    = 3'h7;

endpackage : wavegen_pkg
`default_nettype wire

// file: logic/phase_counter.sv
`timescale 1ns/1ns
`default_nettype none
module phase_counter
(
  // clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  // control
  input  wire logic                       clear_i,
  input  wire logic                       load_i,
  input  wire logic                       step_i,
  input  wire logic [wavegen_pkg::LEN_W-1:0] load_val_i,
  // state
  output logic      [wavegen_pkg::LEN_W-1:0] count_o,
  output logic                            at_term_o
);
  import wavegen_pkg::*;

  logic [LEN_W-1:0] count_q;
  logic [LEN_W-1:0] count_dec;

  assign count_dec = count_q - COUNT_STEP;

  // ----------------------------------------------------------------
  // per-bit forced load, otherwise count down to zero
  // ----------------------------------------------------------------
  for (genvar b = 0; b < LEN_W; b++)
  begin : g_bit
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i || clear_i)
        count_q[b] <= COUNT_RST[b];
      else if (load_i && load_val_i[b])
        count_q[b] <= 1'b1;
      else if (load_i && !load_val_i[b])
        count_q[b] <= 1'b0;
      else if (step_i && (count_q != COUNT_RST))
        count_q[b] <= count_dec[b];
    end
  end

  assign count_o   = count_q;
  assign at_term_o = (count_q == TERM_VALUE);

endmodule : phase_counter
`default_nettype wire

// file: logic/waveform_generator.sv
// Operation
// - low-phase length written on strobe low with address 01 hex.
// - high-phase length written on strobe low with address 00 hex.
// - two 3-bit length registers hold value until rewritten.
// - two 3-bit counters time low and high phases.
// - counters load by forcing each bit set or clear.
// - low counter loads while end pulse low and wave high.
// - high counter loads while end pulse low and wave low.
// - both counters run on the system clock.
// - end pulse registered on system clock, detects counter value 1.
// - end pulse low exactly one clock when a counter reaches 1.
// - wave toggles on each rising edge of the end pulse.
// - start is active low and forces wave register to clear state.
// - clear input forces wave and end pulse quiescent.
// - end pulse register drives its pin inverted.
// - start drives wave low and loads low length; phases alternate.
`timescale 1ns/1ns
`default_nettype none
module waveform_generator
(
  // clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  // host write port (pins)
  input  wire logic                          host_write_strobe_n_i,
  input  wire logic [wavegen_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [wavegen_pkg::LEN_W-1:0]  data_i,
  // sequence control (pins)
  input  wire logic                          start_n_i,
  input  wire logic                          quiescent_init_i,
  // waveform outputs
  output logic                               wave_o,
  output logic                               phase_end_pulse_n_o
);
  import wavegen_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_N-1:0] strobe_n_sync_q;
  logic [SYNC_N-1:0] start_n_sync_q;
  logic [SYNC_N-1:0] init_sync_q;
  logic [ADDR_W-1:0] addr_meta_q;
  logic [ADDR_W-1:0] addr_sync_q;
  logic [LEN_W-1:0]  data_meta_q;
  logic [LEN_W-1:0]  data_sync_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      strobe_n_sync_q <= SYNC_HI_RST;
      start_n_sync_q  <= SYNC_HI_RST;
      init_sync_q     <= SYNC_LO_RST;
    end
    else
    begin
      strobe_n_sync_q <= {strobe_n_sync_q[0], host_write_strobe_n_i};
      start_n_sync_q  <= {start_n_sync_q[0], start_n_i};
      init_sync_q     <= {init_sync_q[0], quiescent_init_i};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      addr_meta_q <= '0;
      addr_sync_q <= '0;
      data_meta_q <= LENGTH_RST;
      data_sync_q <= LENGTH_RST;
    end
    else
    begin
      addr_meta_q <= addr_i;
      addr_sync_q <= addr_meta_q;
      data_meta_q <= data_i;
      data_sync_q <= data_meta_q;
    end
  end

  logic strobe_act;
  logic start_act;
  logic init_act;

  assign strobe_act = !strobe_n_sync_q[SYNC_N-1];
  assign start_act  = !start_n_sync_q[SYNC_N-1];
  assign init_act   = init_sync_q[SYNC_N-1];

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  logic wr_low;
  logic wr_high;

  always_comb
  begin
    wr_low  = 1'b0;
    wr_high = 1'b0;
    if (strobe_act && addr_hit(addr_sync_q, LOW_PHASE_LENGTH_OFS))
      wr_low = 1'b1;
    else if (strobe_act && addr_hit(addr_sync_q, HIGH_PHASE_LENGTH_OFS))
      wr_high = 1'b1;
  end

  // ----------------------------------------------------------------
  // length registers
  // ----------------------------------------------------------------
  logic [LEN_W-1:0] low_phase_length_q;
  logic [LEN_W-1:0] high_phase_length_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      low_phase_length_q <= LENGTH_RST;
    else if (wr_low)
      low_phase_length_q <= data_sync_q;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      high_phase_length_q <= LENGTH_RST;
    else if (wr_high)
      high_phase_length_q <= data_sync_q;
  end

  // ----------------------------------------------------------------
  // phase counters
  // ----------------------------------------------------------------
  logic             pulse_set_q;
  logic             wave_q;
  logic             load_low;
  logic             load_high;
  logic [LEN_W-1:0] low_phase_counter;
  logic [LEN_W-1:0] high_phase_counter;
  logic             low_at_term;
  logic             high_at_term;

  // low load on pulse with wave high
  // start also loads the low length
  assign load_low  = (pulse_set_q && wave_q) || start_act;
  // high load on pulse with wave low
  assign load_high = pulse_set_q && !wave_q && !start_act;

  phase_counter u_low_phase_counter
  (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .clear_i    (init_act),
    .load_i     (load_low),
    .step_i     (!wave_q && !pulse_set_q),
    .load_val_i (low_phase_length_q),
    .count_o    (low_phase_counter),
    .at_term_o  (low_at_term)
  );

  phase_counter u_high_cnt
  (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .clear_i    (init_act || start_act),
    .load_i     (load_high),
    .step_i     (wave_q && !pulse_set_q),
    .load_val_i (high_phase_length_q),
    .count_o    (high_phase_counter),
    .at_term_o  (high_at_term)
  );

  // ----------------------------------------------------------------
  // terminal-count register
  // ----------------------------------------------------------------
  logic term_hit;

  assign term_hit = (!wave_q && low_at_term) || (wave_q && high_at_term);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || init_act || start_act)
      pulse_set_q <= !PULSE_N_RST;
    else
      pulse_set_q <= term_hit && !pulse_set_q;
  end

  // ----------------------------------------------------------------
  // waveform register
  // ----------------------------------------------------------------
  logic pulse_rise;

  // pin rises at the edge that ends the one-clock pulse
  assign pulse_rise = pulse_set_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || init_act)
      wave_q <= WAVE_RST;
    // start holds wave in clear state
    else if (start_act)
      wave_q <= WAVE_RST;
    else if (pulse_rise)
      wave_q <= !wave_q;
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wave_o              <= WAVE_RST;
      phase_end_pulse_n_o <= PULSE_N_RST;
    end
    else
    begin
      wave_o              <= wave_q;
      phase_end_pulse_n_o <= !pulse_set_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_low_write_sel:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (strobe_act && addr_sync_q == LOW_PHASE_LENGTH_OFS) |=>
        low_phase_length_q == $past(data_sync_q))
    else $error("low length not captured");

  a_high_write_sel:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (strobe_act && addr_sync_q == HIGH_PHASE_LENGTH_OFS) |=>
        high_phase_length_q == $past(data_sync_q))
    else $error("high length not captured");

  a_length_hold:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !strobe_act |=> $stable(low_phase_length_q) && $stable(high_phase_length_q))
    else $error("length changed without write");

  a_low_load_val:
    assert property (@(posedge clk_sys_i) disable iff (rst_i || init_act)
      (pulse_set_q && wave_q) |=> low_phase_counter == $past(low_phase_length_q))
    else $error("low counter not loaded");

  a_high_load_val:
    assert property (@(posedge clk_sys_i) disable iff (rst_i || init_act)
      (pulse_set_q && !wave_q && !start_act) |=>
        high_phase_counter == $past(high_phase_length_q))
    else $error("high counter not loaded");

  a_pulse_one_clk:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(phase_end_pulse_n_o) |=> phase_end_pulse_n_o)
    else $error("end pulse longer than one clock");

  a_pulse_cause:
    assert property (@(posedge clk_sys_i) disable iff (rst_i || init_act || start_act)
      term_hit && !pulse_set_q |=> ##1 !phase_end_pulse_n_o)
    else $error("end pulse missing after count 1");

  a_wave_toggle:
    assert property (@(posedge clk_sys_i) disable iff (rst_i || init_act || start_act)
      pulse_rise |=> wave_q != $past(wave_q))
    else $error("wave did not toggle");

  a_wave_only_edge:
    assert property (@(posedge clk_sys_i) disable iff (rst_i || init_act || start_act)
      !pulse_rise |=> $stable(wave_q))
    else $error("wave toggled without edge");

  a_start_force:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      start_act |=> !wave_q ##1 !wave_o)
    else $error("start did not force wave low");

  a_start_load:
    assert property (@(posedge clk_sys_i) disable iff (rst_i || init_act)
      start_act |=> low_phase_counter == $past(low_phase_length_q))
    else $error("start did not load low length");

  a_pin_inverted:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      phase_end_pulse_n_o != $past(pulse_set_q))
    else $error("end pulse pin not inverted");

  a_clear_quiet:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      init_act |=> !wave_q && !pulse_set_q ##1 phase_end_pulse_n_o)
    else $error("clear not quiescent");

  a_count_step:
    assert property (@(posedge clk_sys_i) disable iff (rst_i || init_act || start_act)
      (!wave_q && !pulse_set_q && low_phase_counter > TERM_VALUE) |=>
        low_phase_counter == $past(low_phase_counter) - COUNT_STEP)
    else $error("low counter did not step");

endmodule : waveform_generator
`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model
(
  // clock
  input  wire logic                          clk_sys_i,
  // host pins
  output var  logic                          host_write_strobe_n_o,
  output var  logic [wavegen_pkg::ADDR_W-1:0] addr_o,
  output var  logic [wavegen_pkg::LEN_W-1:0]  data_o,
  // sequence pins
  output var  logic                          start_n_o,
  output var  logic                          quiescent_init_o
);
  import wavegen_pkg::*;

  initial
  begin
    host_write_strobe_n_o = 1'b1;
    addr_o = 8'hff;
    data_o = 3'h0;
    start_n_o = 1'b1;
    quiescent_init_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // host accesses
  // ----------------------------------------------------------------
  // callers pass 2..7
  task automatic write_reg(input logic [ADDR_W-1:0] ofs, input logic [LEN_W-1:0] val);
    @(posedge clk_sys_i);
    host_write_strobe_n_o <= 1'b0;
    addr_o <= ofs;
    data_o <= val;
    repeat (4) @(posedge clk_sys_i);
    // released bus shows no stale value
    host_write_strobe_n_o <= 1'b1;
    addr_o <= ~ofs;
    data_o <= ~val;
    repeat (3) @(posedge clk_sys_i);
  endtask : write_reg

  task automatic start_seq(input int cycles);
    @(posedge clk_sys_i);
    start_n_o <= 1'b0;
    repeat (cycles) @(posedge clk_sys_i);
    start_n_o <= 1'b1;
  endtask : start_seq

  task automatic clear_seq(input int cycles);
    @(posedge clk_sys_i);
    quiescent_init_o <= 1'b1;
    repeat (cycles) @(posedge clk_sys_i);
    quiescent_init_o <= 1'b0;
  endtask : clear_seq

endmodule : host_model
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import wavegen_pkg::*;

  logic              clk_sys_i;
  logic              rst_i;
  logic              strobe_n;
  logic [ADDR_W-1:0] addr;
  logic [LEN_W-1:0]  data;
  logic              start_n;
  logic              clr;
  logic              wave;
  logic              pulse_n;
  logic              mon_en;
  logic              last_wave;
  int                failures;
  int                cmp_count;
  int                low_run;
  int                since_pulse;
  int                n;
  logic [5:0]        lens [3] = '{6'h17, 6'h3a, 6'h1d};

  initial clk_sys_i = 1'b0;
  always #5 clk_sys_i = ~clk_sys_i;

  host_model host (
    .clk_sys_i             (clk_sys_i),
    .host_write_strobe_n_o (strobe_n),
    .addr_o                (addr),
    .data_o                (data),
    .start_n_o             (start_n),
    .quiescent_init_o      (clr)
  );

  waveform_generator DUT (
    .clk_sys_i             (clk_sys_i),
    .rst_i                 (rst_i),
    .host_write_strobe_n_i (strobe_n),
    .addr_i                (addr),
    .data_i                (data),
    .start_n_i             (start_n),
    .quiescent_init_i      (clr),
    .wave_o                (wave),
    .phase_end_pulse_n_o   (pulse_n)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // cycles that wave holds lvl, after waiting for it
  task automatic run_len(input logic lvl, output int len);
    int k;
    k = 0;
    len = 0;
    while (wave !== lvl && k < 64)
    begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    while (wave === lvl && len < 64)
    begin
      @(posedge clk_sys_i);
      #1;
      len++;
    end
    if (k >= 64 || len >= 64)
    begin
      failures++;
      stop_test();
    end
  endtask : run_len

  // pulse width and toggle cause
  always @(posedge clk_sys_i)
  begin
    #1;
    if (rst_i === 1'b0 && pulse_n !== 1'b1)
      low_run++;
    else if (low_run != 0)
    begin
      check(8'(low_run), 8'h01);
      low_run = 0;
    end
    since_pulse = (pulse_n === 1'b0) ? 0 : since_pulse + 1;
    if (mon_en && wave !== last_wave)
      check(8'(since_pulse <= 3), 8'h01);
    last_wave = wave;
  end

  task automatic run_pair(input logic [LEN_W-1:0] lo, input logic [LEN_W-1:0] hi);
    host.write_reg(LOW_PHASE_LENGTH_OFS, lo);
    host.write_reg(HIGH_PHASE_LENGTH_OFS, hi);
    // near-miss addresses must be ignored
    host.write_reg(8'h80, 3'h4);
    host.write_reg(8'h81, 3'h4);
    mon_en = 1'b0;
    host.start_seq(6);
    #1;
    check({7'h00, wave}, 8'h00);
    check({7'h00, pulse_n}, 8'h01);
    mon_en = 1'b1;
    run_len(1'b1, n);
    check(8'(n), 8'({5'h00, hi}) + 8'h01);
    run_len(1'b0, n);
    check(8'(n), 8'({5'h00, lo}) + 8'h01);
    run_len(1'b1, n);
    check(8'(n), 8'({5'h00, hi}) + 8'h01);
    $display("test lengths low %0d high %0d done", lo, hi);
  endtask : run_pair

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    cmp_count = 0;
    low_run = 0;
    since_pulse = 9;
    mon_en = 1'b0;
    last_wave = 1'b0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    check({7'h00, wave}, {7'h00, WAVE_RST});
    check({7'h00, pulse_n}, {7'h00, PULSE_N_RST});
    $display("test reset done");
    foreach (lens[i])
      run_pair(lens[i][5:3], lens[i][2:0]);
    mon_en = 1'b0;
    host.clear_seq(6);
    #1;
    check({7'h00, wave}, 8'h00);
    check({7'h00, pulse_n}, 8'h01);
    repeat (10) @(posedge clk_sys_i);
    #1;
    check({7'h00, wave}, 8'h00);
    $display("test clear done");
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    stop_test();
  end

endmodule : tb_top
`default_nettype wire
